// File: bridge_buffer_decode.v
// Purpose: buffering control, read burst policy and legacy port decode
// Assumes: AXI4-Lite register access, all logic on ref_clk
// Notes: unposted writes never pulse the master release; posted writes release it when the final word is taken
`timescale 1ns/10ps
`include "bridge_buffer_defs.vh"
module bridge_buffer_decode #(
	parameter DATA_W = 32,
	parameter DEPTH_LOG2 = 3,
	parameter LINE_WORDS = 8,
	parameter FIFO_WORDS = 32
) (
	input wire ref_clk, // clock
	input wire reset_n, // async reset, low
	input wire [11:0] s_axi_awaddr, // write address
	input wire s_axi_awvalid, // write address valid
	output wire s_axi_awready, // write address ready
	input wire [31:0] s_axi_wdata, // write data
	input wire [3:0] s_axi_wstrb, // byte strobes
	input wire s_axi_wvalid, // write data valid
	output wire s_axi_wready, // write data ready
	output reg [1:0] s_axi_bresp, // write response
	output reg s_axi_bvalid, // write response valid
	input wire s_axi_bready, // response ready
	input wire [11:0] s_axi_araddr, // read address
	input wire s_axi_arvalid, // read address valid
	output wire s_axi_arready, // read address ready
	output reg [31:0] s_axi_rdata, // read data
	output reg [1:0] s_axi_rresp, // read response
	output reg s_axi_rvalid, // read data valid
	input wire s_axi_rready, // read data ready
	input wire [15:0] ioAddr, // primary io address
	input wire ioStart, // start of primary io cycle
	input wire ioWindowHit, // address inside io forwarding window
	output reg ioClaim, // bridge claims io cycle
	input wire dnRdStart, // downstream memory read starts
	input wire dnRdPrefetch, // read falls in prefetchable window
	output reg dnRdBurst, // downstream read may burst
	input wire upRdStart, // upstream line read starts
	input wire upRdLineEnd, // a cache line has been fetched
	input wire upFifoFull, // upstream fifo full
	output reg upRdFetch, // keep prefetching upstream
	input wire p2sSrcValid, // primary master word valid
	input wire p2sSrcLast, // last word
	input wire [DATA_W-1:0] p2sSrcData, // word
	output wire p2sSrcReady, // word accepted
	output wire p2sSrcRelease, // master released
	output wire p2sDstValid, // word to secondary target
	output wire p2sDstLast, // last flag
	output wire [DATA_W-1:0] p2sDstData, // word
	input wire p2sDstReady, // secondary target took word
	input wire s2pSrcValid, // secondary master word valid
	input wire s2pSrcLast, // last word
	input wire [DATA_W-1:0] s2pSrcData, // word
	output wire s2pSrcReady, // word accepted
	output wire s2pSrcRelease, // master released
	output wire s2pDstValid, // word to primary target
	output wire s2pDstLast, // last flag
	output wire [DATA_W-1:0] s2pDstData, // word
	input wire s2pDstReady, // primary target took word
	output wire p2sIdle, // p2s path empty
	output wire s2pIdle // s2p path empty
);
	// ------------------------------------------------------------
	// register file
	// ------------------------------------------------------------
	reg [7:0] bufCtrl_r;
	reg [7:0] portMap_r;
	reg [7:0] portEn_r;
	reg [7:0] chipCtrl_r;
	reg [11:0] awAddr_r;
	reg awHave_r;
	reg [31:0] wData_r;
	reg [3:0] wStrb_r;
	reg wHave_r;
	wire [9:0] wIdx = awAddr_r[11:2];
	wire [9:0] rIdx = s_axi_araddr[11:2];
	wire doWrite = awHave_r && wHave_r && !s_axi_bvalid;
	assign s_axi_awready = !awHave_r && !s_axi_bvalid;
	assign s_axi_wready = !wHave_r && !s_axi_bvalid;
	assign s_axi_arready = !s_axi_rvalid;
	wire wHitBuf = (wIdx == {2'b00, `BUF_CTRL_IDX});
	wire wHitMap = (wIdx == {2'b00, `PORT_MAP_IDX});
	wire wHitEn = (wIdx == {2'b00, `PORT_EN_IDX});
	wire wHitChip = (wIdx == {2'b00, `CHIP_CTRL_IDX});
	wire wHitAny = wHitBuf || wHitMap || wHitEn || wHitChip;

	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			bufCtrl_r <= `BUF_CTRL_RST;
			portMap_r <= `PORT_MAP_RST;
			portEn_r <= `PORT_EN_RST;
			chipCtrl_r <= `CHIP_CTRL_RST;
			awAddr_r <= 12'h000;
			awHave_r <= 1'b0;
			wData_r <= 32'h0000_0000;
			wStrb_r <= 4'h0;
			wHave_r <= 1'b0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= `AXI_RESP_OKAY;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				awAddr_r <= s_axi_awaddr;
				awHave_r <= 1'b1;
			end
			if (s_axi_wvalid && s_axi_wready) begin
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
				wHave_r <= 1'b1;
			end
			if (doWrite) begin
				awHave_r <= 1'b0;
				wHave_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= wHitAny ? `AXI_RESP_OKAY : `AXI_RESP_SLVERR;
				if (wStrb_r[0]) begin
					if (wHitBuf)
						bufCtrl_r <= wData_r[7:0] & `BUF_CTRL_MASK;
					if (wHitMap)
						portMap_r <= wData_r[7:0] & `PORT_MAP_MASK;
					if (wHitEn)
						portEn_r <= wData_r[7:0] & `PORT_MAP_MASK;
					if (wHitChip)
						chipCtrl_r <= wData_r[7:0] & `CHIP_CTRL_MASK;
				end
			end else if (s_axi_bvalid && s_axi_bready)
				s_axi_bvalid <= 1'b0;
		end
	end

	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0000_0000;
			s_axi_rresp <= `AXI_RESP_OKAY;
		end else if (s_axi_arvalid && s_axi_arready) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `AXI_RESP_OKAY;
			if (rIdx == {2'b00, `BUF_CTRL_IDX})
				s_axi_rdata <= {24'h00_0000, bufCtrl_r};
			else if (rIdx == {2'b00, `PORT_MAP_IDX})
				s_axi_rdata <= {24'h00_0000, portMap_r};
			else if (rIdx == {2'b00, `PORT_EN_IDX})
				s_axi_rdata <= {24'h00_0000, portEn_r};
			else if (rIdx == {2'b00, `CHIP_CTRL_IDX})
				s_axi_rdata <= {24'h00_0000, chipCtrl_r};
			else begin
				s_axi_rdata <= 32'h0000_0000;
				s_axi_rresp <= `AXI_RESP_SLVERR;
			end
		end else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// ------------------------------------------------------------
	// legacy port decode
	// ------------------------------------------------------------
	// bit order: serial a,b,c,d, parallel a,b,c
	wire [6:0] rangeHit;
	assign rangeHit[0] = (ioAddr[15:3] == 13'h007F);
	assign rangeHit[1] = (ioAddr[15:3] == 13'h005F);
	assign rangeHit[2] = (ioAddr[15:3] == 13'h007D);
	assign rangeHit[3] = (ioAddr[15:3] == 13'h005D);
	assign rangeHit[4] = (ioAddr[15:2] == 14'h00EF) || (ioAddr[15:2] == 14'h01EF);
	assign rangeHit[5] = (ioAddr[15:3] == 13'h006F) || (ioAddr[15:2] == 14'h01DE);
	assign rangeHit[6] = (ioAddr[15:3] == 13'h004F) || (ioAddr[15:2] == 14'h019E);
	wire [6:0] legacyClaim;
	wire [6:0] legacyBlock;
	genvar g;
	generate
		for (g = 0; g < 7; g = g + 1) begin : gPort
			assign legacyClaim[g] = rangeHit[g] && portEn_r[g] && portMap_r[g];
			assign legacyBlock[g] = rangeHit[g] && !portMap_r[g];
		end
	endgenerate
	wire claimNow = (|legacyClaim) || (ioWindowHit && !(|legacyBlock));

	// ------------------------------------------------------------
	// read burst policy
	// ------------------------------------------------------------
	reg [15:0] upWords_r;
	reg upMulti_r;
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			ioClaim <= 1'b0;
			dnRdBurst <= 1'b0;
			upRdFetch <= 1'b0;
			upMulti_r <= 1'b0;
			upWords_r <= 16'h0000;
		end else begin
			if (ioStart)
				ioClaim <= claimNow;
			if (dnRdStart)
				dnRdBurst <= dnRdPrefetch && bufCtrl_r[`BIT_DN_BURST];
			if (upRdStart) begin
				upRdFetch <= 1'b1;
				upWords_r <= 16'h0000;
				// chip control bit must be clear
				upMulti_r <= bufCtrl_r[`BIT_UP_BURST] && !chipCtrl_r[`BIT_CHIP_UPDIS];
			end else if (upRdFetch) begin
				if (upRdLineEnd)
					upWords_r <= upWords_r + LINE_WORDS[15:0];
				if (upRdLineEnd && !upMulti_r)
					upRdFetch <= 1'b0;
				// stop no later than fifo full
				else if (upFifoFull || (upWords_r >= FIFO_WORDS[15:0]))
					upRdFetch <= 1'b0;
			end
		end
	end

	// ------------------------------------------------------------
	// write posting paths
	// ------------------------------------------------------------
	// p2s posting by bit 0
	write_forwarder #(.DATA_W(DATA_W), .DEPTH_LOG2(DEPTH_LOG2)) uP2s (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.postEnable(bufCtrl_r[`BIT_P2S_POST]),
		.srcValid(p2sSrcValid),
		.srcLast(p2sSrcLast),
		.srcData(p2sSrcData),
		.srcReady(p2sSrcReady),
		.srcRelease(p2sSrcRelease),
		.dstValid(p2sDstValid),
		.dstLast(p2sDstLast),
		.dstData(p2sDstData),
		.dstReady(p2sDstReady),
		.idle(p2sIdle)
	);
	write_forwarder #(.DATA_W(DATA_W), .DEPTH_LOG2(DEPTH_LOG2)) uS2p (
		.ref_clk(ref_clk),
		.reset_n(reset_n),
		.postEnable(bufCtrl_r[`BIT_S2P_POST]),
		.srcValid(s2pSrcValid),
		.srcLast(s2pSrcLast),
		.srcData(s2pSrcData),
		.srcReady(s2pSrcReady),
		.srcRelease(s2pSrcRelease),
		.dstValid(s2pDstValid),
		.dstLast(s2pDstLast),
		.dstData(s2pDstData),
		.dstReady(s2pDstReady),
		.idle(s2pIdle)
	);
endmodule // bridge_buffer_decode

// File: bridge_buffer_defs.vh
// Purpose: constants for the bridge buffering and legacy port decode block
// Assumes: AXI4-Lite byte addressing, offsets are register indices
// Notes: byte address is four times the index
`ifndef BRIDGE_BUFFER_DEFS_VH
`define BRIDGE_BUFFER_DEFS_VH

`define BUF_CTRL_IDX 8'h59
`define PORT_MAP_IDX 8'h5A
`define PORT_EN_IDX 8'h58
`define CHIP_CTRL_IDX 8'h40
`define BUF_CTRL_RST 8'h07
`define PORT_MAP_RST 8'h00
`define PORT_EN_RST 8'h00
`define CHIP_CTRL_RST 8'h00
`define BUF_CTRL_MASK 8'h17
`define PORT_MAP_MASK 8'h7F
`define CHIP_CTRL_MASK 8'h10
`define BIT_P2S_POST 0
`define BIT_S2P_POST 1
`define BIT_DN_BURST 2
`define BIT_UP_BURST 4
`define BIT_CHIP_UPDIS 4
`define AXI_RESP_OKAY 2'b00
`define AXI_RESP_SLVERR 2'b10

`endif

// File: bridge_buffer_monitor.sv
// Purpose: port-level checks for the bridge buffering and port decode block
// Assumes: one clock domain, reset_n asynchronous and active low
// Notes: register contents are hidden here, so only port relations are checked
`timescale 1ns/10ps
module bridge_buffer_monitor #(
	parameter DATA_W = 32
) (
	input wire ref_clk, // clock
	input wire reset_n, // reset, low
	input wire s_axi_awvalid, // aw valid
	input wire s_axi_awready, // aw ready
	input wire s_axi_wvalid, // w valid
	input wire s_axi_wready, // w ready
	input wire s_axi_bvalid, // b valid
	input wire s_axi_arvalid, // ar valid
	input wire s_axi_arready, // ar ready
	input wire s_axi_rvalid, // r valid
	input wire [31:0] s_axi_rdata, // r data
	input wire [15:0] ioAddr, // io address
	input wire ioStart, // io cycle start
	input wire ioWindowHit, // inside io window
	input wire ioClaim, // claim decision
	input wire dnRdStart, // down read start
	input wire dnRdPrefetch, // prefetchable
	input wire dnRdBurst, // burst allowed
	input wire upRdStart, // up read start
	input wire upFifoFull, // fifo full
	input wire upRdFetch, // prefetching
	input wire p2sSrcValid, // source valid
	input wire p2sSrcReady, // source ready
	input wire p2sSrcLast, // last word
	input wire p2sSrcRelease, // master released
	input wire p2sDstValid, // dst valid
	input wire p2sDstReady, // dst ready
	input wire [DATA_W-1:0] p2sDstData // dst word
);
	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (!reset_n);

	a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
		&& s_axi_wready |-> ##2 s_axi_bvalid) else $error("no write response after handshake");
	a_busy_refuses: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
		else $error("write taken while response pending");
	a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid
		&& s_axi_rdata[31:8] == 24'h00_0000) else $error("read answer late or wide");
	a_claim_outside: assert property (ioStart && !ioWindowHit && ioAddr[15:11] != 5'h00
		|=> !ioClaim) else $error("claim outside window and legacy ranges");
	a_nopf_noburst: assert property (dnRdStart && !dnRdPrefetch |=> !dnRdBurst)
		else $error("burst outside prefetchable window");
	a_fetch_full: assert property (upFifoFull && !upRdStart |=> !upRdFetch)
		else $error("prefetch continued with fifo full");
	a_dst_holds: assert property (p2sDstValid && !p2sDstReady |=> p2sDstValid
		&& $stable(p2sDstData)) else $error("dst word dropped before taken");
	a_take_forwards: assert property (p2sSrcValid && p2sSrcReady |-> ##2 p2sDstValid)
		else $error("taken word not forwarded");
	a_release_last: assert property (p2sSrcRelease |-> p2sSrcValid && p2sSrcReady
		&& p2sSrcLast) else $error("release without last word");
endmodule // bridge_buffer_monitor

bind bridge_buffer_decode bridge_buffer_monitor #(.DATA_W(DATA_W)) i_mon (.*);

// File: tb_bridge_buffer_decode.sv
// Purpose: register, decode, read policy and write path tests
// Assumes: AXI4-Lite byte address is four times the register index
// Notes: expected values come from the register map and decode ranges
`timescale 1ns/10ps
module tb_bridge_buffer_decode;
	reg ref_clk = 0, reset_n = 0;
	reg [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
	reg [31:0] s_axi_wdata = 0;
	reg [3:0] s_axi_wstrb = 4'hF;
	reg s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
	wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	wire [1:0] s_axi_bresp, s_axi_rresp;
	wire [31:0] s_axi_rdata;
	reg [15:0] ioAddr = 0;
	reg ioStart = 0, ioWindowHit = 0, dnRdStart = 0, dnRdPrefetch = 0;
	reg upRdStart = 0, upRdLineEnd = 0, upFifoFull = 0;
	wire ioClaim, dnRdBurst, upRdFetch;
	reg [1:0] sV = 0, sL = 0, stall = 0, np = 0;
	reg [31:0] sD [0:1];
	wire [1:0] srcRdy, rel, dV, dL, dRdy, idle;
	wire [31:0] dD [0:1];
	wire [31:0] tk [0:1];
	wire [31:0] lastD [0:1];
	integer miscompares = 0, checks_done = 0, viol = 0, i, j;
	integer nrel [0:1];
	integer nTake [0:1], nLast [0:1];
	reg [15:0] la [0:9] = '{16'h03FF, 16'h02F8, 16'h03EF, 16'h02E8, 16'h03BC,
		16'h07BF, 16'h037F, 16'h0778, 16'h0278, 16'h067B};
	reg [2:0] lb [0:9] = '{3'd0, 3'd1, 3'd2, 3'd3, 3'd4, 3'd4, 3'd5, 3'd5, 3'd6, 3'd6};

	bridge_buffer_decode i_dut (.*,
		.p2sSrcValid(sV[0]), .p2sSrcLast(sL[0]), .p2sSrcData(sD[0]), .p2sSrcReady(srcRdy[0]),
		.p2sSrcRelease(rel[0]), .p2sDstValid(dV[0]), .p2sDstLast(dL[0]), .p2sDstData(dD[0]),
		.p2sDstReady(dRdy[0]), .s2pSrcValid(sV[1]), .s2pSrcLast(sL[1]), .s2pSrcData(sD[1]),
		.s2pSrcReady(srcRdy[1]), .s2pSrcRelease(rel[1]), .s2pDstValid(dV[1]),
		.s2pDstLast(dL[1]), .s2pDstData(dD[1]), .s2pDstReady(dRdy[1]),
		.p2sIdle(idle[0]), .s2pIdle(idle[1]));
	write_target_model i_tgt0 (.ref_clk(ref_clk), .reset_n(reset_n), .stall(stall[0]),
		.dstValid(dV[0]), .dstData(dD[0]), .dstReady(dRdy[0]), .lastData(lastD[0]), .taken(tk[0]));
	write_target_model i_tgt1 (.ref_clk(ref_clk), .reset_n(reset_n), .stall(stall[1]),
		.dstValid(dV[1]), .dstData(dD[1]), .dstReady(dRdy[1]), .lastData(lastD[1]), .taken(tk[1]));

	always #5 ref_clk = ~ref_clk;

	// one word at a time means no take while a word is in flight
	always @(posedge ref_clk) begin
		for (j = 0; j < 2; j = j + 1) begin
			if (np[j] && sV[j] && srcRdy[j] && (nTake[j] != tk[j]))
				viol <= viol + 1;
			if (sV[j] && srcRdy[j])
				nTake[j] <= nTake[j] + 1;
			if (rel[j])
				nrel[j] <= nrel[j] + 1;
			if (dV[j] && dRdy[j] && dL[j])
				nLast[j] <= nLast[j] + 1;
		end
	end

	task chk(input [31:0] s, input [31:0] e);
		begin
			checks_done = checks_done + 1;
			if (s !== e) begin
				miscompares = miscompares + 1;
				$display("MISMATCH t=%0t seen=%h exp=%h", $time, s, e);
			end
		end
	endtask

	task results;
		begin
			$display("checks=%0d mismatches=%0d", checks_done, miscompares);
			if (miscompares == 0 && checks_done > 0)
				$display("SIMULATION PASSED");
			else
				$display("SIMULATION FAILED");
			$finish;
		end
	endtask

	task axw(input [11:0] a, input [7:0] d, input [1:0] er);
		reg ta, tw;
		begin
			@(posedge ref_clk);
			s_axi_awaddr <= a;
			s_axi_wdata <= {24'h00_0000, d};
			s_axi_awvalid <= 1'b1;
			s_axi_wvalid <= 1'b1;
			s_axi_bready <= 1'b1;
			@(negedge ref_clk);
			while (s_axi_awvalid || s_axi_wvalid) begin
				ta = s_axi_awvalid && s_axi_awready;
				tw = s_axi_wvalid && s_axi_wready;
				@(posedge ref_clk);
				if (ta) s_axi_awvalid <= 1'b0;
				if (tw) s_axi_wvalid <= 1'b0;
				@(negedge ref_clk);
			end
			while (!s_axi_bvalid) @(negedge ref_clk);
			chk(s_axi_bresp, er);
			@(posedge ref_clk);
			s_axi_bready <= 1'b0;
		end
	endtask

	task axr(input [11:0] a, input [31:0] e, input [1:0] er);
		begin
			@(posedge ref_clk);
			s_axi_araddr <= a;
			s_axi_arvalid <= 1'b1;
			s_axi_rready <= 1'b1;
			@(negedge ref_clk);
			while (!s_axi_arready) @(negedge ref_clk);
			@(posedge ref_clk);
			s_axi_arvalid <= 1'b0;
			@(negedge ref_clk);
			while (!s_axi_rvalid) @(negedge ref_clk);
			chk(s_axi_rdata, e);
			chk(s_axi_rresp, er);
			@(posedge ref_clk);
			s_axi_rready <= 1'b0;
		end
	endtask

	// ev: 0 start, 1 line end, 2 fifo full, 3 downstream read
	task pulse(input [15:0] a, input h, input [1:0] ev, input e);
		begin
			@(posedge ref_clk);
			ioAddr <= a;
			ioWindowHit <= h;
			dnRdPrefetch <= h;
			ioStart <= (ev == 2'd0) && (a != 16'h0000);
			upRdStart <= (ev == 2'd0) && (a == 16'h0000);
			upRdLineEnd <= ev == 2'd1;
			upFifoFull <= ev == 2'd2;
			dnRdStart <= ev == 2'd3;
			@(posedge ref_clk);
			{ioStart, upRdStart, upRdLineEnd, upFifoFull, dnRdStart} <= 5'h00;
			#1;
			chk(ev == 2'd3 ? dnRdBurst : a != 16'h0000 ? ioClaim : upRdFetch, e);
		end
	endtask

	task burst(input s, input [2:0] n, input st, input unp);
		integer k, t0, r0, l0;
		begin
			t0 = tk[s];
			r0 = nrel[s];
			l0 = nLast[s];
			for (k = 0; k < n; k = k + 1) begin
				@(posedge ref_clk);
				stall[s] <= st;
				np[s] <= unp;
				sV[s] <= 1'b1;
				sD[s] <= 32'hA000_0000 + s * 256 + k;
				sL[s] <= k == n - 1;
				@(negedge ref_clk);
				while (!srcRdy[s]) @(negedge ref_clk);
			end
			@(posedge ref_clk);
			sV[s] <= 1'b0;
			@(negedge ref_clk);
			while (!idle[s] || dV[s]) @(negedge ref_clk);
			chk(tk[s] - t0, n);
			chk(lastD[s], 32'hA000_0000 + s * 256 + n - 1);
			chk(nrel[s] - r0, !unp);
			chk(nLast[s] - l0, 1);
		end
	endtask

	initial begin
		nrel[0] = 0;
		nrel[1] = 0;
		nTake[0] = 0;
		nTake[1] = 0;
		nLast[0] = 0;
		nLast[1] = 0;
		sD[0] = 0;
		sD[1] = 0;
		repeat (3) @(posedge ref_clk);
		reset_n <= 1'b1;
		axr(12'h164, 32'h0000_0007, 2'b00);
		axr(12'h168, 32'h0000_0000, 2'b00);
		axr(12'h200, 32'h0000_0000, 2'b10);
		axw(12'h200, 8'h55, 2'b10);
		pulse(16'h0000, 1'b1, 2'd3, 1'b1);
		pulse(16'h0000, 1'b0, 2'd3, 1'b0);
		pulse(16'h0000, 1'b0, 2'd0, 1'b1);
		pulse(16'h0000, 1'b0, 2'd1, 1'b0);
		axw(12'h164, 8'hE8, 2'b00);
		axr(12'h164, 32'h0000_0000, 2'b00);
		pulse(16'h0000, 1'b1, 2'd3, 1'b0);
		axw(12'h164, 8'hFF, 2'b00);
		axr(12'h164, 32'h0000_0017, 2'b00);
		pulse(16'h0000, 1'b0, 2'd0, 1'b1);
		pulse(16'h0000, 1'b0, 2'd1, 1'b1);
		pulse(16'h0000, 1'b0, 2'd2, 1'b0);
		axw(12'h100, 8'h10, 2'b00);
		pulse(16'h0000, 1'b0, 2'd0, 1'b1);
		pulse(16'h0000, 1'b0, 2'd1, 1'b0);
		axw(12'h168, 8'hFF, 2'b00);
		axr(12'h168, 32'h0000_007F, 2'b00);
		axw(12'h160, 8'h7E, 2'b00);
		pulse(16'h03F8, 1'b0, 2'd0, 1'b0);
		pulse(16'h0BF8, 1'b0, 2'd0, 1'b0);
		pulse(16'h1000, 1'b1, 2'd0, 1'b1);
		pulse(16'h067C, 1'b0, 2'd0, 1'b0);
		axw(12'h160, 8'h7F, 2'b00);
		for (i = 0; i < 10; i = i + 1) begin
			axw(12'h168, 8'h01 << lb[i], 2'b00);
			pulse(la[i], 1'b0, 2'd0, 1'b1);
			axw(12'h168, 8'h7F ^ (8'h01 << lb[i]), 2'b00);
			pulse(la[i], 1'b1, 2'd0, 1'b0);
		end
		burst(1'b0, 3'd5, 1'b1, 1'b0);
		burst(1'b1, 3'd5, 1'b1, 1'b0);
		axw(12'h164, 8'h14, 2'b00);
		burst(1'b0, 3'd4, 1'b1, 1'b1);
		burst(1'b1, 3'd4, 1'b0, 1'b1);
		chk(viol, 0);
		results;
	end

	initial begin
		#200000;
		miscompares = miscompares + 1;
		results;
	end
endmodule // tb_bridge_buffer_decode

// File: write_forwarder.v
// Purpose: one direction of write forwarding, posted or word by word
// Assumes: source and destination handshakes on ref_clk
// Notes: posting mode is latched at the start of each burst
`timescale 1ns/10ps
module write_forwarder #(
	parameter DATA_W = 32,
	parameter DEPTH_LOG2 = 3
) (
	input wire ref_clk, // clock
	input wire reset_n, // async reset, low
	input wire postEnable, // posting allowed for new bursts
	input wire srcValid, // source master word valid
	input wire srcLast, // last word of burst
	input wire [DATA_W-1:0] srcData, // source word
	output wire srcReady, // word accepted
	output wire srcRelease, // master released on final word, posted mode only
	output reg dstValid, // word to destination
	output reg dstLast, // last flag to destination
	output reg [DATA_W-1:0] dstData, // destination word
	input wire dstReady, // destination took word
	output wire idle // nothing buffered
);
	localparam DEPTH = 1 << DEPTH_LOG2;
	reg [DATA_W:0] mem [0:DEPTH-1];
	reg [DEPTH_LOG2:0] wrPtr_r;
	reg [DEPTH_LOG2:0] rdPtr_r;
	reg inBurst_r;
	reg burstPost_r;
	reg holdLast_r;
	wire [DEPTH_LOG2:0] used = wrPtr_r - rdPtr_r;
	wire full = used[DEPTH_LOG2];
	wire empty = (used == {(DEPTH_LOG2+1){1'b0}});
	wire outBusy = dstValid;
	wire drained = empty && !outBusy;
	wire modeNow = inBurst_r ? burstPost_r : postEnable;
	// posted: buffer while room; unposted: drain first, then one word at a time
	assign srcReady = srcValid && (modeNow ? !full : (drained && !holdLast_r));
	wire take = srcReady;
	wire pop = !empty && (!dstValid || dstReady);
	// unposted: release never pulses; new words wait until destination accepts the final word
	assign srcRelease = modeNow ? (take && srcLast) : 1'b0;
	assign idle = drained && !inBurst_r;
	wire unpostDone = holdLast_r && dstValid && dstReady && dstLast;

	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			wrPtr_r <= {(DEPTH_LOG2+1){1'b0}};
			rdPtr_r <= {(DEPTH_LOG2+1){1'b0}};
			inBurst_r <= 1'b0;
			burstPost_r <= 1'b1;
			holdLast_r <= 1'b0;
			dstValid <= 1'b0;
			dstLast <= 1'b0;
			dstData <= {DATA_W{1'b0}};
		end else begin
			if (take) begin
				mem[wrPtr_r[DEPTH_LOG2-1:0]] <= {srcLast, srcData};
				wrPtr_r <= wrPtr_r + 1'b1;
			end
			if (take && !inBurst_r)
				burstPost_r <= postEnable;
			if (take && srcLast)
				inBurst_r <= modeNow ? 1'b0 : 1'b1;
			else if (take)
				inBurst_r <= 1'b1;
			if (take && srcLast && !modeNow)
				holdLast_r <= 1'b1;
			else if (unpostDone) begin
				holdLast_r <= 1'b0;
				inBurst_r <= 1'b0;
			end
			if (pop) begin
				{dstLast, dstData} <= mem[rdPtr_r[DEPTH_LOG2-1:0]];
				rdPtr_r <= rdPtr_r + 1'b1;
				dstValid <= 1'b1;
			end else if (dstReady)
				dstValid <= 1'b0;
		end
	end
endmodule // write_forwarder

// File: write_target_model.sv
// Purpose: target at the far end of one write path
// Assumes: dst handshake sampled on ref_clk
// Notes: stall toggles ready so words must wait a cycle each
`timescale 1ns/10ps
module write_target_model (
	input wire ref_clk, // clock
	input wire reset_n, // reset, low
	input wire stall, // slow target
	input wire dstValid, // word offered
	input wire [31:0] dstData, // word
	output reg dstReady, // word taken
	output reg [31:0] lastData, // last word taken
	output reg [31:0] taken // words taken
);
	always @(posedge ref_clk or negedge reset_n) begin
		if (!reset_n) begin
			dstReady <= 1'b0;
			lastData <= 32'h0000_0000;
			taken <= 32'h0000_0000;
		end else begin
			dstReady <= stall ? ~dstReady : 1'b1;
			if (dstValid && dstReady) begin
				lastData <= dstData;
				taken <= taken + 32'h0000_0001;
			end
		end
	end
endmodule // write_target_model
